// ---- design/external_enable_sequencer.sv ----
// external enable sequencer: two enable outputs, one raised by slot timer, power-good, pin or register, the other by slot timer only
// assumes register access strobes and power-good signals come from logic on ref_clk
`timescale 1ns/100ps
`default_nettype none
`include "ext_enable_map.svh"
module external_enable_sequencer
  import ext_enable_pkg::*;
#(
  parameter int SLOT_CYCLES = (`EE_SLOT_STEP_US * 1000 + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS,
  parameter int DELAY_CYCLES = (`EE_DELAY_STEP_US * 1000 + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // wake-up sequence and monitored signals
  input wire logic seq_run,
  input wire logic [7:0] power_good,
  input wire logic [3:0] gp_pin_in,
  // enable outputs
  output logic ext_enable_out_one,
  output logic ext_enable_out_two
);
  localparam int PW = (SLOT_CYCLES > 1) ? $clog2(SLOT_CYCLES) : 1;

  if (SLOT_CYCLES < 2) begin : g_chk
    $error("SLOT_CYCLES must be at least 2");
  end

  // ****************************************
  // registers
  // ****************************************
  logic [4:0] out_one_slot_r;
  logic [4:0] out_one_slot_nxt;
  logic [4:0] out_two_slot_r;
  logic [4:0] out_two_slot_nxt;
  source_cfg_type src_r;
  source_cfg_type src_nxt;
  logic [7:0] delay_r;
  logic [7:0] delay_nxt;
  logic gp_level_r;
  logic gp_level_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [4:0] slot_count_r;

  always_comb begin
    out_one_slot_nxt = out_one_slot_r;
    out_two_slot_nxt = out_two_slot_r;
    src_nxt = src_r;
    delay_nxt = delay_r;
    gp_level_nxt = gp_level_r;
    rdata_nxt = rdata_r;
    if (reg_wr) begin
      if (reg_addr == `EE_OFS_SLOT_ONE) begin
        out_one_slot_nxt = reg_wdata[4:0];
      end else if (reg_addr == `EE_OFS_SLOT_TWO) begin
        out_two_slot_nxt = reg_wdata[4:0];
      end else if (reg_addr == `EE_OFS_SOURCE) begin
        src_nxt = reg_wdata[7:1];
      end else if (reg_addr == `EE_OFS_DELAY) begin
        delay_nxt = reg_wdata;
      end else if (reg_addr == `EE_OFS_STATUS) begin
        gp_level_nxt = reg_wdata[0];
      end
    end
    // read data is registered; unmapped offsets answer zero
    if (reg_rd) begin
      if (reg_addr == `EE_OFS_SLOT_ONE) begin
        rdata_nxt = {3'h0, out_one_slot_r};
      end else if (reg_addr == `EE_OFS_SLOT_TWO) begin
        rdata_nxt = {3'h0, out_two_slot_r};
      end else if (reg_addr == `EE_OFS_SOURCE) begin
        rdata_nxt = {src_r, 1'b0};
      end else if (reg_addr == `EE_OFS_DELAY) begin
        rdata_nxt = delay_r;
      end else if (reg_addr == `EE_OFS_STATUS) begin
        rdata_nxt = {slot_count_r, ext_enable_out_two, ext_enable_out_one, gp_level_r};
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_one_slot_r <= `EE_RST_SLOT;
      out_two_slot_r <= `EE_RST_SLOT;
      src_r <= '{out_one_source_select: source_type'(`EE_RST_SOURCE), out_one_powergood_select: 3'h0,
                 out_one_pin_select: 2'h0};
      delay_r <= `EE_RST_DELAY;
      gp_level_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      out_one_slot_r <= out_one_slot_nxt;
      out_two_slot_r <= out_two_slot_nxt;
      src_r <= src_nxt;
      delay_r <= delay_nxt;
      gp_level_r <= gp_level_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // pin synchroniser
  // ****************************************
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end else begin
      pin_meta_r <= gp_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ****************************************
  // slot timer
  // ****************************************
  timer_state_type state_r;
  timer_state_type state_nxt;
  logic [PW-1:0] pre_r;
  logic [PW-1:0] pre_nxt;
  logic [4:0] slot_count_nxt;

  // dropping seq_run resets the timer so the next wake-up starts again at slot 1
  always_comb begin
    state_nxt = state_r;
    pre_nxt = pre_r;
    slot_count_nxt = slot_count_r;
    case (state_r)
      ST_IDLE: begin
        pre_nxt = '0;
        slot_count_nxt = 5'h00;
        if (seq_run) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!seq_run) begin
          state_nxt = ST_IDLE;
        end else if (pre_r == PW'(SLOT_CYCLES - 1)) begin
          pre_nxt = '0;
          slot_count_nxt = slot_count_r + 5'h01;
          if (slot_count_r + 5'h01 == `EE_SLOT_MAX) begin
            state_nxt = ST_HOLD;
          end
        end else begin
          pre_nxt = pre_r + PW'(1);
        end
      end
      ST_HOLD: begin
        if (!seq_run) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      pre_r <= '0;
      slot_count_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      pre_r <= pre_nxt;
      slot_count_r <= slot_count_nxt;
    end
  end

  // ****************************************
  // trigger selection and outputs
  // ****************************************
  logic slot_one_hit;
  logic slot_two_hit;
  logic trig_one;
  logic fire_one;
  logic fire_two;
  logic out_one_r;
  logic out_one_nxt;
  logic out_two_r;

  // slot n is reached once the count reaches n-1; a zero slot never fires
  assign slot_one_hit = (state_r != ST_IDLE) && (out_one_slot_r != 5'h00) &&
                        (slot_count_r >= out_one_slot_r - 5'h01);
  assign slot_two_hit = (state_r != ST_IDLE) && (out_two_slot_r != 5'h00) &&
                        (slot_count_r >= out_two_slot_r - 5'h01);

  always_comb begin
    trig_one = 1'b0;
    case (src_r.out_one_source_select)
      SRC_POWER_GOOD: trig_one = power_good[src_r.out_one_powergood_select];
      SRC_PIN: trig_one = pin_sync_r[src_r.out_one_pin_select];
      SRC_SLOT: trig_one = slot_one_hit;
      default: trig_one = 1'b0;
    endcase
    // register mode bypasses the delay channel
    out_one_nxt = (src_r.out_one_source_select == SRC_REGISTER) ? gp_level_r : fire_one;
  end

  rise_delay_channel #(.DELAY_CYCLES(DELAY_CYCLES)) u_chan_one (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .trig(trig_one),
    .delay_steps(delay_r[`EE_DLY_ONE_HI:`EE_DLY_ONE_LO]),
    .fire(fire_one)
  );

  rise_delay_channel #(.DELAY_CYCLES(DELAY_CYCLES)) u_chan_two (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .trig(slot_two_hit),
    .delay_steps(delay_r[`EE_DLY_TWO_HI:`EE_DLY_TWO_LO]),
    .fire(fire_two)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_one_r <= 1'b0;
      out_two_r <= 1'b0;
    end else begin
      out_one_r <= out_one_nxt;
      out_two_r <= fire_two;
    end
  end

  assign ext_enable_out_one = out_one_r;
  assign ext_enable_out_two = out_two_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  slot_one_off_a: assert property ((src_r.out_one_source_select == SRC_SLOT && out_one_slot_r == 5'h00)[*3]
    |-> !out_one_r) else $error("output one raised with zero slot");
  slot_two_off_a: assert property ((out_two_slot_r == 5'h00)[*3] |-> !out_two_r)
    else $error("output two raised with zero slot");
  slot_count_step_a: assert property ((state_r == ST_RUN && seq_run && pre_r == PW'(SLOT_CYCLES - 1))
    |=> slot_count_r == $past(slot_count_r) + 5'h01) else $error("slot count did not advance");
  // a zero delay must carry the slot hit through channel and output flop within two edges
  slot_two_hit_a: assert property ((slot_two_hit && delay_r[`EE_DLY_TWO_HI:`EE_DLY_TWO_LO] == 4'h0)[*3]
    |-> out_two_r) else $error("output two missed its slot");
  powergood_follow_a: assert property ((src_r.out_one_source_select == SRC_POWER_GOOD &&
    delay_r[`EE_DLY_ONE_HI:`EE_DLY_ONE_LO] == 4'h0 && power_good[src_r.out_one_powergood_select])[*3]
    |-> out_one_r) else $error("selected power-good not followed");
  pin_follow_a: assert property ((src_r.out_one_source_select == SRC_PIN &&
    delay_r[`EE_DLY_ONE_HI:`EE_DLY_ONE_LO] == 4'h0 && pin_sync_r[src_r.out_one_pin_select])[*3]
    |-> out_one_r) else $error("selected pin not followed");
  register_level_a: assert property ((src_r.out_one_source_select == SRC_REGISTER)[*2]
    |-> out_one_r == $past(gp_level_r)) else $error("register level not followed");
  rise_has_cause_a: assert property ($rose(out_one_r) && $past(src_r.out_one_source_select) != SRC_REGISTER
    |-> $past(trig_one, 2)) else $error("output one rose without trigger");
  timer_idle_a: assert property (!seq_run |=> slot_count_r == 5'h00 || state_r == ST_IDLE)
    else $error("timer kept running without sequence");

  slot_rise_c: cover property (src_r.out_one_source_select == SRC_SLOT && $rose(out_one_r));
  pin_rise_c: cover property (src_r.out_one_source_select == SRC_PIN && $rose(out_one_r));
  two_rise_c: cover property ($rose(out_two_r));
endmodule
`default_nettype wire

// ---- design/ext_enable_map.svh ----
// register offsets, field positions, reset values and timing figures of the external enable sequencer
// assumes a single 250 MHz core clock and byte-wide register access from the serial control block
`ifndef EXT_ENABLE_MAP_SVH
`define EXT_ENABLE_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define EE_OFS_SLOT_ONE 8'h14
`define EE_OFS_SLOT_TWO 8'h15
`define EE_OFS_SOURCE 8'h16
`define EE_OFS_DELAY 8'h18
`define EE_OFS_STATUS 8'h1F

// ****************************************
// reset values
// ****************************************
`define EE_RST_SLOT 5'h07
`define EE_RST_SOURCE 2'h3
`define EE_RST_DELAY 8'h00

// ****************************************
// field positions
// ****************************************
`define EE_SRC_SEL_HI 7
`define EE_SRC_SEL_LO 6
`define EE_PG_SEL_HI 5
`define EE_PG_SEL_LO 3
`define EE_PIN_SEL_HI 2
`define EE_PIN_SEL_LO 1
`define EE_DLY_ONE_HI 7
`define EE_DLY_ONE_LO 4
`define EE_DLY_TWO_HI 3
`define EE_DLY_TWO_LO 0
`define EE_SLOT_MAX 5'h1F

// ****************************************
// timing
// ****************************************
`define EE_CLK_PERIOD_NS 4
`define EE_SLOT_STEP_US 250
`define EE_DELAY_STEP_US 250

`endif

// ---- design/ext_enable_pkg.sv ----
// types shared by the external enable sequencer files
// assumes ext_enable_map.svh for the numeric constants
package ext_enable_pkg;

  typedef enum logic [1:0] {
    SRC_POWER_GOOD = 2'h0,
    SRC_PIN = 2'h1,
    SRC_REGISTER = 2'h2,
    SRC_SLOT = 2'h3
  } source_type;

  typedef struct packed {
    source_type out_one_source_select;
    logic [2:0] out_one_powergood_select;
    logic [1:0] out_one_pin_select;
  } source_cfg_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } timer_state_type;

endpackage

// ---- design/rise_delay_channel.sv ----
// one enable channel: raises its output once the trigger has stood high for the programmed delay
// assumes the trigger is already in the ref_clk domain
`timescale 1ns/100ps
`default_nettype none
module rise_delay_channel #(
  parameter int DELAY_CYCLES = 62500
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // trigger and setting
  input wire logic trig,
  input wire logic [3:0] delay_steps,
  // result
  output logic fire
);
  localparam int PW = (DELAY_CYCLES > 1) ? $clog2(DELAY_CYCLES) : 1;

  if (DELAY_CYCLES < 2) begin : g_chk
    $error("DELAY_CYCLES must be at least 2");
  end

  logic [PW-1:0] pre_r;
  logic [PW-1:0] pre_nxt;
  logic [3:0] step_r;
  logic [3:0] step_nxt;
  logic fire_r;
  logic fire_nxt;

  // own prescaler so the delay starts exactly at the trigger, not at a shared tick
  always_comb begin
    pre_nxt = pre_r;
    step_nxt = step_r;
    fire_nxt = fire_r;
    if (!trig) begin
      pre_nxt = '0;
      step_nxt = 4'h0;
      fire_nxt = 1'b0;
    end else if (!fire_r) begin
      if (step_r >= delay_steps) begin
        fire_nxt = 1'b1;
      end else if (pre_r == PW'(DELAY_CYCLES - 1)) begin
        pre_nxt = '0;
        step_nxt = step_r + 4'h1;
      end else begin
        pre_nxt = pre_r + PW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= '0;
      step_r <= 4'h0;
      fire_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      step_r <= step_nxt;
      fire_r <= fire_nxt;
    end
  end

  assign fire = fire_r;

  trig_low_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !trig |=> !fire_r) else $error("channel fired without trigger");
  delay_zero_fast_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (trig && delay_steps == 4'h0 && step_r == 4'h0)[*2] |-> fire_r) else $error("zero delay not immediate");
  step_needs_time_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (step_r != $past(step_r) && step_r != 4'h0) |-> $past(pre_r) == PW'(DELAY_CYCLES - 1))
    else $error("delay step taken early");
endmodule
`default_nettype wire

// ---- tb/rail_model.sv ----
// downstream rail model: reports good a fixed ramp after its enable rises
// assumes the enable comes from the sequencer on ref_clk
`timescale 1ns/100ps
`default_nettype none
module rail_model #(
  parameter int RAMP = 3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // enable and status
  input wire logic en,
  output logic good
);
  // ****************************************
  // ramp
  // ****************************************
  int cnt_r;
  // good drops as soon as the enable goes, a real rail discharges without warning
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b || !en) cnt_r <= 0;
    else if (cnt_r < RAMP) cnt_r <= cnt_r + 1;
  end
  assign good = en && (cnt_r == RAMP);
endmodule
`default_nettype wire

// ---- tb/external_enable_sequencer_tb_top.sv ----
// self-checking bench for the external enable sequencer
// assumes short slot and delay counts of 8 cycles and rail models on both outputs
`timescale 1ns/100ps
`default_nettype none
`include "ext_enable_map.svh"
module external_enable_sequencer_tb_top;
  import ext_enable_pkg::*;
  localparam int S = 8;
  logic ref_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, seq_run = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, power_good = 8'h00, reg_rdata;
  logic [3:0] gp_pin_in = 4'h0;
  logic ext_enable_out_one, ext_enable_out_two, good_one, good_two;
  int error_cnt = 0, checks = 0, cyc = 0, t0 = 0, t1 = 0, t2 = 0, i, n1, n2, d1, d2;

  external_enable_sequencer #(.SLOT_CYCLES(S), .DELAY_CYCLES(S)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .seq_run(seq_run), .power_good(power_good), .gp_pin_in(gp_pin_in),
    .ext_enable_out_one(ext_enable_out_one), .ext_enable_out_two(ext_enable_out_two));
  rail_model #(.RAMP(1)) rail_one_u (.ref_clk(ref_clk), .rst_b(rst_b), .en(ext_enable_out_one), .good(good_one));
  rail_model #(.RAMP(5)) rail_two_u (.ref_clk(ref_clk), .rst_b(rst_b), .en(ext_enable_out_two), .good(good_two));

  // ****************************************
  // clock, cycle count and rise recorder
  // ****************************************
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  // sampled on the falling edge so the record never races the output flops
  always @(negedge ref_clk) begin
    if (ext_enable_out_one === 1'b1 && t1 < 0) t1 = cyc;
    if (ext_enable_out_two === 1'b1 && t2 < 0) t2 = cyc;
  end

  // ****************************************
  // tasks and expectations
  // ****************************************
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick(1);
    reg_wr = 0;
    tick(1);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] x, input string m);
    reg_addr = a;
    reg_rd = 1;
    tick(1);
    reg_rd = 0;
    tick(1);
    chk(reg_rdata, x, m);
  endtask
  task arm;
    t0 = cyc;
    t1 = -1;
    t2 = -1;
  endtask
  task idle;
    seq_run = 0;
    power_good = 8'h00;
    gp_pin_in = 4'h0;
    tick(6);
  endtask
  // rise seen within a few cycles of the expected count, flop and sync stages allowed for
  function automatic bit near(int t, int e);
    return t >= 0 && t - t0 >= e - 1 && t - t0 <= e + 3;
  endfunction
  function automatic bit slot_ok(int t, int n, int d);
    return (n == 0) ? (t < 0) : near(t, S * (n - 1 + d) + 3);
  endfunction
  task print_verdict;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    // the tests need about 3500 cycles; seven times that is a hang
    #100000;
    error_cnt++;
    print_verdict;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(76));
    tick(12);
    rst_b = 1;
    tick(1);
    rdc(`EE_OFS_SLOT_ONE, 8'h07, "slot one reset");
    rdc(`EE_OFS_SLOT_TWO, 8'h07, "slot two reset");
    rdc(`EE_OFS_SOURCE, 8'hC0, "source reset");
    rdc(`EE_OFS_DELAY, 8'h00, "delay reset");
    rdc(8'h10, 8'h00, "unmapped read");
    wr(`EE_OFS_SLOT_ONE, 8'hFF);
    rdc(`EE_OFS_SLOT_ONE, 8'h1F, "slot reserved bits");
    $display("test registers done");
    for (i = 0; i < 6; i++) begin
      n1 = (i == 0) ? 1 : (i == 1) ? 31 : (i == 2) ? 0 : $urandom_range(31, 1);
      n2 = (i == 0) ? 0 : $urandom_range(31, 0);
      d1 = (i < 2) ? 0 : $urandom_range(15, 0);
      d2 = (i == 1) ? 0 : $urandom_range(15, 0);
      wr(`EE_OFS_SLOT_ONE, 8'(n1));
      wr(`EE_OFS_SLOT_TWO, 8'(n2));
      wr(`EE_OFS_DELAY, 8'(d1 * 16 + d2));
      wr(`EE_OFS_SOURCE, 8'hC0);
      arm;
      seq_run = 1;
      tick(S * 46 + 12);
      chk(8'(slot_ok(t1, n1, d1)), 8'h01, "slot one rise");
      chk(8'(slot_ok(t2, n2, d2)), 8'h01, "slot two rise");
      chk({7'h00, ext_enable_out_one}, 8'(n1 != 0), "slot one holds");
      chk({7'h00, good_two}, 8'(n2 != 0), "rail two good");
      // long past slot 31, so the count has saturated and each output with a nonzero slot stands
      rdc(`EE_OFS_STATUS, {5'h1F, n2 != 0, n1 != 0, 1'b0}, "slot count saturates");
      idle;
    end
    $display("test slots done");
    for (i = 0; i < 8; i++) begin
      d1 = (i == 0) ? 0 : $urandom_range(7, 0);
      wr(`EE_OFS_DELAY, 8'(d1 * 16));
      wr(`EE_OFS_SOURCE, {SRC_POWER_GOOD, 3'(i), 2'h0, 1'b0});
      arm;
      power_good = ~(8'h01 << i);
      tick(30);
      chk(8'(t1 < 0), 8'h01, "other power good ignored");
      arm;
      power_good = 8'hFF;
      tick(S * d1 + 10);
      chk(8'(near(t1, S * d1 + 2)), 8'h01, "power good rise");
      power_good = 8'h00;
      tick(4);
      chk({7'h00, ext_enable_out_one}, 8'h00, "power good follow");
      idle;
    end
    $display("test power good done");
    for (i = 0; i < 4; i++) begin
      d1 = (i == 0) ? 0 : $urandom_range(7, 0);
      wr(`EE_OFS_DELAY, 8'(d1 * 16));
      wr(`EE_OFS_SOURCE, {SRC_PIN, 3'h0, 2'(i), 1'b0});
      arm;
      gp_pin_in = ~(4'h1 << i);
      tick(30);
      chk(8'(t1 < 0), 8'h01, "other pin ignored");
      arm;
      gp_pin_in = 4'hF;
      tick(S * d1 + 12);
      chk(8'(near(t1, S * d1 + 4)), 8'h01, "pin rise");
      idle;
    end
    $display("test pins done");
    wr(`EE_OFS_DELAY, 8'hF0);
    wr(`EE_OFS_SOURCE, {SRC_REGISTER, 6'h00});
    arm;
    wr(`EE_OFS_STATUS, 8'h01);
    tick(4);
    chk(8'(near(t1, 3)), 8'h01, "register level rise");
    chk({7'h00, good_one}, 8'h01, "rail one good");
    rdc(`EE_OFS_STATUS, 8'h03, "status level");
    wr(`EE_OFS_STATUS, 8'h00);
    tick(3);
    chk({7'h00, ext_enable_out_one}, 8'h00, "register level fall");
    $display("test register mode done");
    print_verdict;
  end
endmodule
`default_nettype wire
